/* File: src/logic_cell_pkg.sv */
/*
  Constants for the logic cell configuration slice: register offsets,
  field positions, source codes and reset values.
  Assumes a byte-wide register port addressed by the printed offsets.
*/
package logic_cell_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [15:0] POLARITY_OFFSET     = 16'h1E11;
  localparam logic [15:0] DATA_ONE_OFFSET     = 16'h1E12;
  localparam logic [15:0] DATA_TWO_OFFSET     = 16'h1E13;
  localparam logic [15:0] DATA_THREE_OFFSET   = 16'h1E14;
  localparam logic [15:0] GATE_IN_OFFSET      = 16'h1E40;

  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 8;
  localparam int SRC_W     = 6;
  localparam int NUM_GATES = 4;
  localparam int NUM_SRCS  = 64;

  // ------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------
  localparam int OUT_INV_BIT = 7;

  // Values a power-on reset leaves in fields whose documented state is unknown, the system reset value of the output invert and the zero read value
  localparam logic [3:0]       GATE_INV_POR = 4'h0;
  localparam logic [SRC_W-1:0] SOURCE_POR   = 6'h00;
  localparam logic             OUT_INV_RST  = 1'b0;
  localparam logic [7:0]       READ_ZERO    = 8'h00;

  // ------------------------------------------------------------
  // Source codes
  // ------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_PIN_FIRST   = 6'h00;
  localparam logic [SRC_W-1:0] SRC_SYSCLK      = 6'h04;
  localparam logic [SRC_W-1:0] SRC_REFCLK      = 6'h0B;
  localparam logic [SRC_W-1:0] SRC_TIMER_FIRST = 6'h0C;
  localparam logic [SRC_W-1:0] SRC_CAPT_FIRST  = 6'h14;
  localparam logic [SRC_W-1:0] SRC_MOD         = 6'h1F;
  localparam logic [SRC_W-1:0] SRC_CELL_FIRST  = 6'h20;
  localparam logic [SRC_W-1:0] SRC_SER_FIRST   = 6'h24;
  localparam logic [SRC_W-1:0] SRC_RSV_A       = 6'h28;
  localparam logic [SRC_W-1:0] SRC_RSV_B       = 6'h29;
  localparam logic [SRC_W-1:0] SRC_WAVE_FIRST  = 6'h2A;
  localparam logic [SRC_W-1:0] SRC_WAVE_LAST   = 6'h2D;

  // Mask of codes that carry a real source: 0..39 and 42..45
  localparam logic [NUM_SRCS-1:0] SRC_VALID_MASK = 64'h0000_3CFF_FFFF_FFFF;

endpackage

/* File: src/source_bus_if.sv */
/*
  Carries the 64 synchronised source lines from the synchroniser into the selectors.
  Assumes one clock domain on both ends.
*/
`timescale 1ns/1ps
interface source_bus_if;
  import logic_cell_pkg::*;
  logic [NUM_SRCS-1:0] lines;
  modport producer (output lines);
  modport consumer (input lines);
endinterface

/* File: src/source_sync.sv */
/*
  Two-flop synchroniser for every source line.
  Assumes sources may change at any time relative to clock_in.
*/
`timescale 1ns/1ps
module source_sync
  import logic_cell_pkg::*;
(
  // Clock and reset
  input  wire logic                clock_in,
  input  wire logic                sys_rst_in,
  // Raw sources
  input  wire logic [NUM_SRCS-1:0] raw_in,
  // Synchronised sources
  source_bus_if.producer           bus
);
  logic [NUM_SRCS-1:0] meta_q;
  logic [NUM_SRCS-1:0] sync_q;

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  assign bus.lines = sync_q;
endmodule

/* File: src/source_mux.sv */
/*
  One 64-way source selector; reserved codes give a constant zero.
  Assumes synchronised source lines.
*/
`timescale 1ns/1ps
module source_mux
  import logic_cell_pkg::*;
(
  // Selection
  input  wire logic [SRC_W-1:0] code_in,
  // Sources
  source_bus_if.consumer        bus,
  // Result
  output logic                  data_out
);
  always_comb
  begin
    if (SRC_VALID_MASK[code_in])
      data_out = bus.lines[code_in];  // see [R07] see [R08] see [R09]
    else
      data_out = 1'b0;                // see [R12]
  end
endmodule

/* File: src/logic_cell_config.sv */
/*
  Configuration slice of a configurable logic cell: polarity register,
  three data source selectors and the gate and output polarity paths.
  Assumes a byte register port with one-cycle strobes and read data one
  cycle later, and sources that are asynchronous to clock_in.
*/
// The address-and-strobe port was decided locally.
//
// Operation
// [R01] Output invert bit set inverts the final cell output; clear passes it.
// [R02] Each gate invert bit 0..3 inverts its gate before the cell function.
// [R03] Gate invert bits unknown after power-on; other resets keep them.
// [R04] Data one select bits 5..0 pick the source of data input one.
// [R05] Data two select bits 5..0 pick data input two, same coding.
// [R06] Data three select bits 5..0 pick the source of data input three.
// [R07] Codes 0-3 pins, 4 system clock, 5-10 oscillators, 11 reference clock.
// [R08] Codes 12-19 timers, 20-23 capture, 24-31 PWM and analog events.
// [R09] Codes 32-35 cells, 36-39 serial, 42-45 waveform; others reserved.
// [R10] Select fields unknown after power-on; other resets keep them.
// [R11] Polarity register: output invert bit 7, gate inverts bits 3..0, output resets 0.
// [R12] Reserved source code drives its data input to constant zero.
`timescale 1ns/1ps
module logic_cell_config
  import logic_cell_pkg::*;
(
  // Clock and resets
  input  wire logic                 clock_in,
  input  wire logic                 sys_rst_in,
  input  wire logic                 por_rst_in,
  // Register port
  input  wire logic [ADDR_W-1:0]    reg_addr_in,
  input  wire logic [DATA_W-1:0]    reg_wdata_in,
  input  wire logic                 reg_write_in,
  input  wire logic                 reg_read_in,
  output logic      [DATA_W-1:0]    reg_rdata_out,
  // Sources and cell datapath
  input  wire logic [NUM_SRCS-1:0]  source_in,
  input  wire logic [NUM_GATES-1:0] gate_raw_in,
  input  wire logic                 cell_core_in,
  output logic      [2:0]           data_sel_out,
  output logic      [NUM_GATES-1:0] gate_to_cell_out,
  output logic                      cell_result_out
);

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic                 cell_output_invert_q;
  logic [NUM_GATES-1:0] gate_output_invert_q;
  logic [SRC_W-1:0]     input_one_source_q;
  logic [SRC_W-1:0]     input_two_source_q;
  logic [SRC_W-1:0]     input_three_source_q;
  logic [NUM_GATES-1:0] gate_sync_meta_q;
  logic [NUM_GATES-1:0] gate_sync_q;
  logic                 core_meta_q;
  logic                 core_sync_q;

  logic wr_invert;
  logic wr_one;
  logic wr_two;
  logic wr_three;
  assign wr_invert = reg_write_in && (reg_addr_in == POLARITY_OFFSET);
  assign wr_one    = reg_write_in && (reg_addr_in == DATA_ONE_OFFSET);
  assign wr_two    = reg_write_in && (reg_addr_in == DATA_TWO_OFFSET);
  assign wr_three  = reg_write_in && (reg_addr_in == DATA_THREE_OFFSET);

  // Output invert clears on the system reset (sys_rst_in) only
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      cell_output_invert_q <= OUT_INV_RST;                 // see [R11]
    else if (wr_invert)
      cell_output_invert_q <= reg_wdata_in[OUT_INV_BIT];   // see [R11]
  end

  // Gate inverts and selectors survive the system reset; only power-on
  // loads them, with a fixed value standing for the unknown state
  always_ff @(posedge clock_in or posedge por_rst_in)
  begin
    if (por_rst_in)
      gate_output_invert_q <= GATE_INV_POR;                 // see [R03]
    else if (wr_invert)
      gate_output_invert_q <= reg_wdata_in[NUM_GATES-1:0];  // see [R11]
  end

  always_ff @(posedge clock_in or posedge por_rst_in)
  begin
    if (por_rst_in)
    begin
      input_one_source_q   <= SOURCE_POR;                   // see [R10]
      input_two_source_q   <= SOURCE_POR;
      input_three_source_q <= SOURCE_POR;
    end
    else
    begin
      if (wr_one)
        input_one_source_q <= reg_wdata_in[SRC_W-1:0];      // see [R04]
      if (wr_two)
        input_two_source_q <= reg_wdata_in[SRC_W-1:0];      // see [R05]
      if (wr_three)
        input_three_source_q <= reg_wdata_in[SRC_W-1:0];    // see [R06]
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= READ_ZERO;
    else if (reg_read_in)
    begin
      case (reg_addr_in)
        POLARITY_OFFSET:   reg_rdata_out <= {cell_output_invert_q, 3'h0, gate_output_invert_q};
        DATA_ONE_OFFSET:   reg_rdata_out <= {2'h0, input_one_source_q};
        DATA_TWO_OFFSET:   reg_rdata_out <= {2'h0, input_two_source_q};
        DATA_THREE_OFFSET: reg_rdata_out <= {2'h0, input_three_source_q};
        GATE_IN_OFFSET:    reg_rdata_out <= {4'h0, gate_sync_q};
        default:           reg_rdata_out <= READ_ZERO;
      endcase
    end
    else
      reg_rdata_out <= READ_ZERO;
  end

  // ------------------------------------------------------------
  // Source selection
  // ------------------------------------------------------------
  source_bus_if src_bus ();

  source_sync u_sync (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .raw_in     (source_in),
    .bus        (src_bus.producer)
  );

  logic [2:0]       mux_out;
  logic [SRC_W-1:0] sel_code [3];
  assign sel_code[0] = input_one_source_q;
  assign sel_code[1] = input_two_source_q;
  assign sel_code[2] = input_three_source_q;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sel
      source_mux u_mux (
        .code_in  (sel_code[gi]),
        .bus      (src_bus.consumer),
        .data_out (mux_out[gi])
      );
    end
  endgenerate

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      data_sel_out <= 3'h0;
    else
      data_sel_out <= mux_out;   // see [R04] see [R05] see [R06]
  end

  // ------------------------------------------------------------
  // Polarity datapath
  // ------------------------------------------------------------
  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      gate_sync_meta_q <= '0;
      gate_sync_q      <= '0;
      core_meta_q      <= 1'b0;
      core_sync_q      <= 1'b0;
    end
    else
    begin
      gate_sync_meta_q <= gate_raw_in;
      gate_sync_q      <= gate_sync_meta_q;
      core_meta_q      <= cell_core_in;
      core_sync_q      <= core_meta_q;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      gate_to_cell_out <= '0;
      cell_result_out  <= 1'b0;
    end
    else
    begin
      gate_to_cell_out <= gate_sync_q ^ gate_output_invert_q;  // see [R02]
      cell_result_out  <= core_sync_q ^ cell_output_invert_q;  // see [R01]
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  out_invert_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R01]
    !sys_rst_in |=> cell_result_out == ($past(core_sync_q) ^ $past(cell_output_invert_q)))
    else $error("cell result polarity wrong");

  // Gate inverts survive a warm reset while the output flops clear, so the
  // release edge itself is left out
  gate_invert_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R02]
    !sys_rst_in |=> gate_to_cell_out == ($past(gate_sync_q) ^ $past(gate_output_invert_q)))
    else $error("gate polarity wrong");

  gate_keep_a: assert property (@(posedge clock_in) disable iff (por_rst_in) // see [R03]
    !wr_invert |=> gate_output_invert_q == $past(gate_output_invert_q))
    else $error("gate invert changed without write");

  sel_one_a: assert property (@(posedge clock_in) disable iff (por_rst_in) // see [R04]
    wr_one |=> input_one_source_q == $past(reg_wdata_in[SRC_W-1:0]))
    else $error("data one select not stored");

  sel_two_a: assert property (@(posedge clock_in) disable iff (por_rst_in) // see [R05]
    wr_two |=> input_two_source_q == $past(reg_wdata_in[SRC_W-1:0]))
    else $error("data two select not stored");

  sel_three_a: assert property (@(posedge clock_in) disable iff (por_rst_in) // see [R06]
    wr_three |=> input_three_source_q == $past(reg_wdata_in[SRC_W-1:0]))
    else $error("data three select not stored");

  sel_route_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R07]
    (input_one_source_q < SRC_RSV_A) |=> data_sel_out[0] == $past(src_bus.lines[input_one_source_q]))
    else $error("data one routed wrong");

  wave_route_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R09]
    (input_two_source_q >= SRC_WAVE_FIRST && input_two_source_q <= SRC_WAVE_LAST)
    |=> data_sel_out[1] == $past(src_bus.lines[input_two_source_q]))
    else $error("waveform source routed wrong");

  rsv_zero_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R12]
    !SRC_VALID_MASK[input_three_source_q] |=> !data_sel_out[2])
    else $error("reserved code not zero");

  sel_hold_a: assert property (@(posedge clock_in) disable iff (por_rst_in) // see [R10]
    !wr_one |=> $stable(input_one_source_q))
    else $error("data one select changed");

  out_rst_a: assert property (@(posedge clock_in) // see [R11]
    $fell(sys_rst_in) |-> !cell_output_invert_q)
    else $error("output invert not cleared");

  // ------------------------------------------------------------
  // Register and routing checks
  // ------------------------------------------------------------
  out_store_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R11]
    wr_invert
    |=> cell_output_invert_q == $past(reg_wdata_in[OUT_INV_BIT]))
    else $error("output invert not stored");

  out_keep_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R11]
    !wr_invert
    |=> $stable(cell_output_invert_q))
    else $error("output invert changed without write");

  gate_store_a: assert property (@(posedge clock_in) disable iff (por_rst_in) // see [R11]
    wr_invert
    |=> gate_output_invert_q == $past(reg_wdata_in[NUM_GATES-1:0]))
    else $error("gate invert not stored");

  two_hold_a: assert property (@(posedge clock_in) disable iff (por_rst_in) // see [R10]
    !wr_two
    |=> $stable(input_two_source_q))
    else $error("data two select changed");

  three_hold_a: assert property (@(posedge clock_in) disable iff (por_rst_in) // see [R10]
    !wr_three
    |=> $stable(input_three_source_q))
    else $error("data three select changed");

  read_invert_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R11]
    reg_read_in && (reg_addr_in == POLARITY_OFFSET)
    |=> reg_rdata_out == {$past(cell_output_invert_q), 3'h0, $past(gate_output_invert_q)})
    else $error("polarity read wrong");

  read_one_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R04]
    reg_read_in && (reg_addr_in == DATA_ONE_OFFSET)
    |=> reg_rdata_out == {2'h0, $past(input_one_source_q)})
    else $error("data one read wrong");

  read_two_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R05]
    reg_read_in && (reg_addr_in == DATA_TWO_OFFSET)
    |=> reg_rdata_out == {2'h0, $past(input_two_source_q)})
    else $error("data two read wrong");

  read_three_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R06]
    reg_read_in && (reg_addr_in == DATA_THREE_OFFSET)
    |=> reg_rdata_out == {2'h0, $past(input_three_source_q)})
    else $error("data three read wrong");

  route_two_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R08]
    (input_two_source_q < SRC_RSV_A)
    |=> data_sel_out[1] == $past(src_bus.lines[input_two_source_q]))
    else $error("data two routed wrong");

  route_three_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R07]
    (input_three_source_q < SRC_RSV_A)
    |=> data_sel_out[2] == $past(src_bus.lines[input_three_source_q]))
    else $error("data three routed wrong");

  wave_one_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R09]
    (input_one_source_q >= SRC_WAVE_FIRST && input_one_source_q <= SRC_WAVE_LAST)
    |=> data_sel_out[0] == $past(src_bus.lines[input_one_source_q]))
    else $error("waveform source one routed wrong");

  wave_three_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R09]
    (input_three_source_q >= SRC_WAVE_FIRST && input_three_source_q <= SRC_WAVE_LAST)
    |=> data_sel_out[2] == $past(src_bus.lines[input_three_source_q]))
    else $error("waveform source three routed wrong");

  rsv_one_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R12]
    !SRC_VALID_MASK[input_one_source_q]
    |=> !data_sel_out[0])
    else $error("reserved code one not zero");

  rsv_two_a: assert property (@(posedge clock_in) disable iff (sys_rst_in) // see [R12]
    !SRC_VALID_MASK[input_two_source_q]
    |=> !data_sel_out[1])
    else $error("reserved code two not zero");

  rst_outs_a: assert property (@(posedge clock_in) // see [R01]
    $fell(sys_rst_in)
    |-> data_sel_out == 3'h0 && gate_to_cell_out == '0 && !cell_result_out && reg_rdata_out == READ_ZERO)
    else $error("outputs not cleared by reset");

endmodule

/* File: verification/periph_model.sv */
/*
  Stand-in for the on-chip peripherals, clocks and gates that feed the cell.
  Assumes the bench sets the wanted levels; they reach the block one edge later.
*/
`timescale 1ns/1ps
module periph_model
  import logic_cell_pkg::*;
(
  // Clock
  input  wire logic                 clock_in,
  // Levels commanded by the bench
  input  wire logic [NUM_SRCS-1:0]  src_level_in,
  input  wire logic [NUM_GATES-1:0] gate_level_in,
  input  wire logic                 core_level_in,
  // Lines into the block
  output logic      [NUM_SRCS-1:0]  source_out,
  output logic      [NUM_GATES-1:0] gate_out,
  output logic                      core_out
);
  always_ff @(posedge clock_in)
  begin
    source_out <= src_level_in;
    gate_out   <= gate_level_in;
    core_out   <= core_level_in;
  end
endmodule

/* File: verification/logic_cell_config_test.sv */
/*
  Self-checking bench for the logic cell configuration slice.
  Assumes the periph_model stand-in drives sources, gates and the cell core input.
*/
`timescale 1ns/1ps
module logic_cell_config_test;
  import logic_cell_pkg::*;
  logic                 clock_in, sys_rst_in, por_rst_in;
  logic [ADDR_W-1:0]    reg_addr_in;
  logic [DATA_W-1:0]    reg_wdata_in, reg_rdata_out, rd;
  logic                 reg_write_in, reg_read_in, core_level, core_line, cell_result_out;
  logic [NUM_SRCS-1:0]  src_level, source_line;
  logic [NUM_GATES-1:0] gate_level, gate_line, gate_to_cell_out;
  logic [2:0]           data_sel_out;
  int                   mismatches, checked, cycles;
  logic [15:0]          sel_addr [3] = '{DATA_ONE_OFFSET, DATA_TWO_OFFSET, DATA_THREE_OFFSET};

  logic_cell_config uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .por_rst_in(por_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .source_in(source_line),
    .gate_raw_in(gate_line), .cell_core_in(core_line), .data_sel_out(data_sel_out),
    .gate_to_cell_out(gate_to_cell_out), .cell_result_out(cell_result_out));
  periph_model far_side (.clock_in(clock_in), .src_level_in(src_level), .gate_level_in(gate_level),
    .core_level_in(core_level), .source_out(source_line), .gate_out(gate_line), .core_out(core_line));

  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // ------------------------------------------------------------
  // Bus cycles and comparison
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus_write(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clock_in);
    reg_write_in <= 1'b1;
    reg_addr_in  <= addr;
    reg_wdata_in <= data;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask

  task automatic bus_read(input logic [15:0] addr, output logic [7:0] data);
    @(posedge clock_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= addr;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1 data = reg_rdata_out;
  endtask

  task automatic read_check(input string what, input logic [15:0] addr, input logic [7:0] exp);
    bus_read(addr, rd);
    check(what, rd, exp);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_power_on;
    read_check("polarity after power-on", POLARITY_OFFSET, 8'h00);
    for (int i = 0; i < 3; i++)
      read_check("select after power-on", sel_addr[i], 8'h00);
    bus_write(16'h1E15, 8'hFF);
    read_check("unmapped read", 16'h1E15, 8'h00);
  endtask

  task automatic test_field_widths;
    bus_write(POLARITY_OFFSET, 8'hFF);
    read_check("polarity fields", POLARITY_OFFSET, 8'h8F);
    for (int i = 0; i < 3; i++)
    begin
      bus_write(sel_addr[i], 8'hFF);
      read_check("select field", sel_addr[i], 8'h3F);
    end
  endtask

  task automatic test_source_codes;
    logic [2:0] exp;
    for (int s = 0; s < 3; s++)
    begin
      for (int c = 0; c < 64; c++)
      begin
        bus_write(sel_addr[s], 8'(c));
        src_level <= 64'h1 << c;
        repeat (6) @(posedge clock_in);
        exp = (c <= 39 || (c >= 42 && c <= 45)) ? 3'(1 << s) : 3'h0;
        #1 check("selected source high", 8'(data_sel_out), 8'(exp));
        src_level <= ~(64'h1 << c);
        repeat (6) @(posedge clock_in);
        #1 check("selected source low", 8'(data_sel_out), 8'h00);
      end
      bus_write(sel_addr[s], 8'h3F);
    end
  endtask

  task automatic test_polarity;
    logic [7:0] setting [3] = '{8'h85, 8'h00, 8'h8A};
    for (int i = 0; i < 3; i++)
    begin
      bus_write(POLARITY_OFFSET, setting[i]);
      gate_level <= 4'h3;
      core_level <= 1'b0;
      repeat (6) @(posedge clock_in);
      #1 check("gates into cell", 8'(gate_to_cell_out), {4'h0, 4'h3 ^ setting[i][3:0]});
      check("cell result", 8'(cell_result_out), {7'h00, setting[i][7]});
      core_level <= 1'b1;
      repeat (6) @(posedge clock_in);
      #1 check("cell result high", 8'(cell_result_out), {7'h00, !setting[i][7]});
    end
    read_check("gate readback", GATE_IN_OFFSET, 8'h03);
  endtask

  task automatic test_warm_reset;
    bus_write(POLARITY_OFFSET, 8'h8A);
    bus_write(DATA_ONE_OFFSET, 8'h2A);
    bus_write(DATA_TWO_OFFSET, 8'h15);
    bus_write(DATA_THREE_OFFSET, 8'h0B);
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    read_check("polarity kept", POLARITY_OFFSET, 8'h0A);
    read_check("data one kept", DATA_ONE_OFFSET, 8'h2A);
    read_check("data two kept", DATA_TWO_OFFSET, 8'h15);
    read_check("data three kept", DATA_THREE_OFFSET, 8'h0B);
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic complete_run;
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  initial
  begin
    sys_rst_in   = 1'b1;
    por_rst_in   = 1'b1;
    reg_addr_in  = '0;
    reg_wdata_in = '0;
    reg_write_in = 1'b0;
    reg_read_in  = 1'b0;
    src_level    = '0;
    gate_level   = '0;
    core_level   = 1'b0;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    por_rst_in <= 1'b0;
    test_power_on();
    test_field_widths();
    test_source_codes();
    test_polarity();
    test_warm_reset();
    complete_run();
  end
endmodule
